// File: design/osd_i2c_consts.vh
// Constants for the two-wire write decoder of the display controller
// Functional notes
// - Transfer opens with START then address byte; device receives only, answers address 7A.
// - On address match the device pulls data low during the ninth clock.
// - Each later byte is eight bits plus acknowledge; device acknowledges every byte.
// - After address, accept any-length stream of row, column and data bytes.
// - Address byte MSB one means row address, zero means column address.
// - Column byte bit 6 one selects auto-increment format c, zero formats a/b.
// - Format a writes data to row and column sent just before it.
// - Format b keeps last row; further column and data pairs use it.
// - Format c takes start once, all later bytes are data, location increments.
// - Formats may change a to b, a to c, b to a; c holds until end.
// - Row bits 6..5 pick display, attribute/control or font target with row field.
// - Font is 18 by 12 dots, two bytes per dot row, 36 columns, 6-bit column.
// - Font number equals font row address, columns 0 to 35; the font column field here accepts 0 to 63.
// - Glitches up to 100 ns on clock and data lines are not taken as edges.
// - Display enable is bit 7 of control row 15 column 17, resets to zero.
`ifndef OSD_I2C_CONSTS_VH
`define OSD_I2C_CONSTS_VH
// ============================================================
// Bus identity and timing
`define SLAVE_ADDR 7'h3d
`define CLK_PERIOD_NS 8
`define GLITCH_NS 100
`define GLITCH_CYCLES ((`GLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// ============================================================
// Byte fields
`define BIT_IS_ROW 7
`define BIT_ROW_FONT 6
`define BIT_ROW_ATTR 5
`define BIT_COL_AUTO 6
// ============================================================
// Targets
`define TGT_DISP 2'h0
`define TGT_ATTR 2'h1
`define TGT_FONT 2'h2
// ============================================================
// Screen control
`define CTRL_ROW 4'hf
`define CTRL_COL 6'h11
`define CTRL_EN_BIT 7
`define FONT_COLS 6'h24
`endif

// File: design/glitch_filter.v
// Two-flop synchroniser followed by a spike filter
module glitch_filter #(
   parameter CYCLES = 13
) (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Pin and filtered level
   input wire pin,
   output reg level
);
   reg meta;
   reg sync;
   reg [7:0] count;

   always @(posedge clk) begin
      if (sys_rst) begin
         meta <= 1'b1;
         sync <= 1'b1;
         level <= 1'b1;
         count <= 8'h00;
      end else begin
         meta <= pin;
         sync <= meta;
         // Level only moves after the input has differed for longer than a spike
         if (sync == level) begin
            count <= 8'h00;
         end else if (count == CYCLES[7:0]) begin
            level <= sync;
            count <= 8'h00;
         end else begin
            count <= count + 8'h01;
         end
      end
   end
endmodule

// File: design/byte_shifter.v
// Shifts bits in on rising bus clock and counts bit position
module byte_shifter (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Control
   input wire clear,
   input wire rise,
   input wire fall,
   input wire sda,
   // Results
   output reg [7:0] data,
   output reg [3:0] bitnum,
   output reg byte_done
);
   always @(posedge clk) begin
      if (sys_rst || clear) begin
         data <= 8'h00;
         // Fall that follows START wraps this to bit 0
         bitnum <= 4'h8;
         byte_done <= 1'b0;
      end else begin
         byte_done <= 1'b0;
         if (rise && bitnum < 4'h8) begin
            data <= {data[6:0], sda};
            if (bitnum == 4'h7) begin
               byte_done <= 1'b1;
            end
         end
         // Count on falling edge so bit 8 spans the acknowledge clock
         if (fall) begin
            bitnum <= (bitnum == 4'h8) ? 4'h0 : bitnum + 4'h1;
         end
      end
   end
endmodule

// File: design/osd_i2c_write_decoder.v
// Receive-only two-wire port decoding row, column and data writes
`include "osd_i2c_consts.vh"
module osd_i2c_write_decoder #(
   parameter GLITCH_CYCLES = `GLITCH_CYCLES
) (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Bus pins
   input wire scl_in,
   input wire sda_in,
   output reg sda_out,
   output reg sda_oe,
   // Decoded write
   output reg wr_stb,
   output reg [1:0] wr_target,
   output reg [3:0] wr_row,
   output reg [5:0] wr_col,
   output reg [7:0] wr_data,
   // Screen control
   output reg display_enable_bit,
   output reg busy
);
   // ============================================================
   // States
   localparam ST_IDLE = 4'b0001;
   localparam ST_ADDR = 4'b0010;
   localparam ST_RECV = 4'b0100;
   localparam ST_IGN = 4'b1000;

   // Decoder phases within a transfer
   localparam PH_ROW = 3'b001;
   localparam PH_COL = 3'b010;
   localparam PH_DATA = 3'b100;

   wire scl;
   wire sda;
   reg scl_d;
   reg sda_d;
   reg [3:0] state;
   reg [2:0] phase;
   reg auto_mode;
   reg [1:0] target;
   reg [3:0] row;
   reg [5:0] col;
   reg ack_pending;
   wire [7:0] rx;
   wire [3:0] bitnum;
   wire byte_done;
   wire rise;
   wire fall;
   wire start_cond;
   wire stop_cond;

   function [1:0] row_target;
      input [7:0] b;
      begin
         if (b[`BIT_ROW_FONT]) begin
            row_target = `TGT_FONT;
         end else if (b[`BIT_ROW_ATTR]) begin
            row_target = `TGT_ATTR;
         end else begin
            row_target = `TGT_DISP;
         end
      end
   endfunction

   function [3:0] row_field;
      input [7:0] b;
      begin
         // Fonts carry a three-bit row, registers four bits
         row_field = b[`BIT_ROW_FONT] ? {1'b0, b[2:0]} : b[3:0];
      end
   endfunction

   function [5:0] col_field;
      input [7:0] b;
      input [1:0] t;
      begin
         col_field = (t == `TGT_FONT) ? b[5:0] : {1'b0, b[4:0]};
      end
   endfunction

   // ============================================================
   // Input conditioning
   glitch_filter #(.CYCLES(GLITCH_CYCLES)) u_scl_filt (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin(scl_in),
      .level(scl)
   );
   glitch_filter #(.CYCLES(GLITCH_CYCLES)) u_sda_filt (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin(sda_in),
      .level(sda)
   );

   always @(posedge clk) begin
      if (sys_rst) begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end

   assign rise = scl && !scl_d;
   assign fall = !scl && scl_d;
   assign start_cond = scl && scl_d && sda_d && !sda;
   assign stop_cond = scl && scl_d && !sda_d && sda;

   byte_shifter u_shift (
      .clk(clk),
      .sys_rst(sys_rst),
      .clear(start_cond || stop_cond),
      .rise(rise),
      .fall(fall),
      .sda(sda),
      .data(rx),
      .bitnum(bitnum),
      .byte_done(byte_done)
   );

   // ============================================================
   // Bus state and acknowledge
   always @(posedge clk) begin
      if (sys_rst) begin
         state <= ST_IDLE;
         ack_pending <= 1'b0;
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         busy <= 1'b0;
      end else begin
         sda_out <= 1'b0;
         busy <= (state != ST_IDLE);
         if (start_cond) begin
            state <= ST_ADDR;
            ack_pending <= 1'b0;
            sda_oe <= 1'b0;
         end else if (stop_cond) begin
            state <= ST_IDLE;
            ack_pending <= 1'b0;
            sda_oe <= 1'b0;
         end else begin
            if (byte_done) begin
               case (state)
                  ST_ADDR: begin
                     // Read requests are not answered: receiver only
                     if (rx[7:1] == `SLAVE_ADDR && !rx[0]) begin
                        state <= ST_RECV;
                        ack_pending <= 1'b1;
                     end else begin
                        state <= ST_IGN;
                     end
                  end
                  ST_RECV: ack_pending <= 1'b1;
                  ST_IDLE: state <= ST_IDLE;
                  ST_IGN: state <= ST_IGN;
                  default: state <= ST_IDLE;
               endcase
            end
            // Drive low from the fall before the ninth clock to the fall after it
            if (fall && ack_pending && bitnum == 4'h7) begin
               sda_oe <= 1'b1;
               ack_pending <= 1'b0;
            end else if (fall && bitnum == 4'h8) begin
               sda_oe <= 1'b0;
            end
         end
      end
   end

   // ============================================================
   // Stream decoding
   always @(posedge clk) begin
      if (sys_rst) begin
         phase <= PH_ROW;
         auto_mode <= 1'b0;
         target <= `TGT_DISP;
         row <= 4'h0;
         col <= 6'h00;
         wr_stb <= 1'b0;
         wr_target <= `TGT_DISP;
         wr_row <= 4'h0;
         wr_col <= 6'h00;
         wr_data <= 8'h00;
         display_enable_bit <= 1'b0;
      end else begin
         wr_stb <= 1'b0;
         if (start_cond || stop_cond) begin
            phase <= PH_ROW;
            auto_mode <= 1'b0;
            target <= `TGT_DISP;
            row <= 4'h0;
            col <= 6'h00;
         end else if (byte_done && state == ST_RECV) begin
            if (auto_mode) begin
               // Once auto mode is entered every byte is data
               wr_stb <= 1'b1;
               wr_target <= target;
               wr_row <= row;
               wr_col <= col;
               wr_data <= rx;
               // Register targets wrap inside their five-bit column field
               col <= (target == `TGT_FONT) ? col + 6'h01 : {1'b0, col[4:0] + 5'h01};
               if (target == `TGT_ATTR && row == `CTRL_ROW && col == `CTRL_COL) begin
                  display_enable_bit <= rx[`CTRL_EN_BIT];
               end
            end else if (phase == PH_DATA) begin
               wr_stb <= 1'b1;
               wr_target <= target;
               wr_row <= row;
               wr_col <= col;
               wr_data <= rx;
               // Row stays for format b, next byte is row or column again
               phase <= PH_COL;
               if (target == `TGT_ATTR && row == `CTRL_ROW && col == `CTRL_COL) begin
                  display_enable_bit <= rx[`CTRL_EN_BIT];
               end
            end else if (rx[`BIT_IS_ROW]) begin
               target <= row_target(rx);
               row <= row_field(rx);
               phase <= PH_COL;
            end else begin
               // Column before any row uses row 0 of the display
               col <= col_field(rx, target);
               auto_mode <= rx[`BIT_COL_AUTO];
               phase <= PH_DATA;
            end
         end
      end
   end
endmodule

// File: bench/osd_i2c_props.sv
// Port checker for the two-wire write decoder
module osd_i2c_props #(
   parameter GLITCH_CYCLES = 13
) (
   // Clock and reset
   input wire clk,
   input wire sys_rst,
   // Bus pins
   input wire scl_in,
   input wire sda_in,
   input wire sda_out,
   input wire sda_oe,
   // Decoded write
   input wire wr_stb,
   input wire [1:0] wr_target,
   input wire [3:0] wr_row,
   input wire [5:0] wr_col,
   input wire [7:0] wr_data,
   // Screen control
   input wire display_enable_bit,
   input wire busy
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   wire ctrl_hit = wr_stb && wr_target == 2'h1 && wr_row == 4'hf && wr_col == 6'h11;
   // ============================================================
   // Properties
   a_drain_low: assert property (sda_out == 1'b0) else $error("data output not low");
   a_ack_clock_low: assert property ($rose(sda_oe) || $fell(sda_oe) |-> !scl_in) else $error("ack edge");
   a_ack_in_transfer: assert property (sda_oe |-> busy) else $error("ack while idle");
   a_ack_width: assert property ($rose(sda_oe) |-> sda_oe [*8]) else $error("ack too short");
   a_stb_pulse: assert property (wr_stb |=> !wr_stb) else $error("write strobe too long");
   a_stb_busy: assert property (wr_stb |-> busy) else $error("write while idle");
   a_target_code: assert property (wr_stb |-> wr_target != 2'h3) else $error("bad target");
   a_font_row: assert property (wr_stb && wr_target == 2'h2 |-> !wr_row[3]) else $error("font row");
   a_col_width: assert property (wr_stb && wr_target != 2'h2 |-> !wr_col[5]) else $error("column");
   a_fields_held: assert property (!wr_stb |-> $stable({wr_target, wr_row, wr_col, wr_data}))
      else $error("fields moved");
   a_enable_load: assert property (ctrl_hit |=> display_enable_bit == $past(wr_data[7]))
      else $error("enable not loaded");
   a_enable_hold: assert property (!ctrl_hit |-> $stable(display_enable_bit))
      else $error("enable moved");
   c_font: cover property (wr_stb && wr_target == 2'h2);
   c_enable: cover property ($rose(display_enable_bit));
   c_ack: cover property ($rose(sda_oe));
endmodule

bind osd_i2c_write_decoder osd_i2c_props #(.GLITCH_CYCLES(GLITCH_CYCLES)) u_osd_i2c_props (.clk(clk),
   .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .wr_stb(wr_stb),
   .wr_target(wr_target), .wr_row(wr_row), .wr_col(wr_col), .wr_data(wr_data),
   .display_enable_bit(display_enable_bit), .busy(busy));

// File: bench/host_model.sv
// Bus master model: clock stands high after a stop, low after a frame that ends without one
module host_model (
   // Clock
   input wire clk,
   // Bus
   input wire sda_line,
   output logic scl,
   output logic sda
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // Quarter bit of four cycles, a bit period near 125 ns
   task automatic step(input logic c, input logic d);
      scl <= c;
      sda <= d;
      repeat (4) @(posedge clk);
   endtask
   task automatic start();
      step(scl, 1'b1);
      step(1'b1, 1'b1);
      step(1'b1, 1'b0);
      step(1'b0, 1'b0);
   endtask
   task automatic stop();
      step(1'b0, 1'b0);
      step(1'b1, 1'b0);
      step(1'b1, 1'b1);
   endtask
   task automatic send_byte(input logic [7:0] b, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         step(1'b0, b[i]);
         step(1'b1, b[i]);
         step(1'b1, b[i]);
         step(1'b0, b[i]);
      end
      // Data released for the ninth clock
      step(1'b0, 1'b1);
      step(1'b1, 1'b1);
      ack = !sda_line;
      step(1'b1, 1'b1);
      step(1'b0, 1'b1);
   endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the two-wire write decoder
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   wire scl, host_sda, sda_out, sda_oe, wr_stb, display_enable_bit, busy;
   wire [1:0] wr_target;
   wire [3:0] wr_row;
   wire [5:0] wr_col;
   wire [7:0] wr_data;
   // Pull-up unless the device pulls low
   wire sda_line = host_sda & ~(sda_oe & ~sda_out);
   int fail_count = 0;
   int total_checks = 0;
   logic exp_en = 1'b0;
   logic [31:0] seed = 32'h00010dc0;
   logic [19:0] seen[$];
   logic [19:0] expq[$];
   always #4 clk = ~clk;
   host_model u_host_model (.clk(clk), .sda_line(sda_line), .scl(scl), .sda(host_sda));
   // Short filter keeps the 125 ns bus clock visible
   osd_i2c_write_decoder #(.GLITCH_CYCLES(2)) u_osd_i2c_write_decoder (.clk(clk), .sys_rst(sys_rst),
      .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .wr_stb(wr_stb),
      .wr_target(wr_target), .wr_row(wr_row), .wr_col(wr_col), .wr_data(wr_data),
      .display_enable_bit(display_enable_bit), .busy(busy));
   always @(posedge clk) begin
      if (wr_stb === 1'b1) seen.push_back({wr_target, wr_row, wr_col, wr_data});
   end
   // ============================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic ok, input string msg);
      total_checks++;
      if (ok !== 1'b1) begin
         fail_count++;
         $display("mismatch at %0t: %s", $time, msg);
      end
   endtask
   function automatic void push(input logic [7:0] r, input logic [7:0] c, input logic [7:0] d);
      logic [1:0] t;
      logic [3:0] rw;
      logic [5:0] cm;
      t = r[6] ? 2'h2 : {1'b0, r[5]};
      rw = r[6] ? {1'b0, r[2:0]} : r[3:0];
      cm = r[6] ? c[5:0] : {1'b0, c[4:0]};
      expq.push_back({t, rw, cm, d});
      if (t == 2'h1 && rw == 4'hf && cm == 6'h11) exp_en = d[7];
   endfunction
   // Reference decode starts afresh at each START
   task automatic frame(input logic [7:0] b[$], input logic ok, input logic last);
      logic ack;
      logic auto;
      logic need;
      logic [7:0] rb;
      logic [7:0] col;
      rb = 8'h80;
      col = 8'h00;
      auto = 1'b0;
      need = 1'b0;
      u_host_model.start();
      foreach (b[i]) begin
         u_host_model.send_byte(b[i], ack);
         check(ack === ok, "acknowledge");
         if (ok && i > 0) begin
            if (auto || need) begin
               push(rb, col, b[i]);
               col = col + 8'h01;
               need = 1'b0;
            end else if (b[i][7]) begin
               rb = b[i];
            end else begin
               col = b[i];
               auto = b[i][6];
               need = !b[i][6];
            end
         end
      end
      if (last) u_host_model.stop();
      repeat (12) @(posedge clk);
      check(seen.size() == expq.size(), "write count");
      foreach (expq[i]) if (i < seen.size()) check(seen[i] === expq[i], "write fields");
      check(display_enable_bit === exp_en, "enable bit");
      check(busy === !last, "busy level");
      seen.delete();
      expq.delete();
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   // ============================================================
   // Sequence
   initial begin
      logic [7:0] q[$];
      logic [31:0] r;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (30) @(posedge clk);
      check(display_enable_bit === 1'b0 && sda_oe === 1'b0, "reset state");
      frame('{8'h7c, 8'h90, 8'h01, 8'h55}, 1'b0, 1'b1);
      frame('{8'h7b, 8'h90, 8'h01}, 1'b0, 1'b1);
      frame('{8'h7a, 8'h83, 8'h05, 8'h11, 8'ha2, 8'h07, 8'h22}, 1'b1, 1'b1);
      frame('{8'h7a, 8'ha4, 8'h01, 8'h31, 8'h02, 8'h32, 8'h8e, 8'h09, 8'h33}, 1'b1, 1'b1);
      frame('{8'h7a, 8'h81, 8'h02, 8'h44, 8'hc5, 8'h62, 8'hff, 8'h80, 8'h00, 8'h5a}, 1'b1, 1'b1);
      frame('{8'h7a, 8'haf, 8'h11, 8'h80}, 1'b1, 1'b1);
      frame('{8'h7a, 8'h85}, 1'b1, 1'b0);
      frame('{8'h7a, 8'h03, 8'h66, 8'haf, 8'h11, 8'h7f}, 1'b1, 1'b1);
      for (int n = 0; n < 6; n++) begin
         q = '{8'h7a};
         for (int k = 0; k < 6; k++) begin
            r = rnd();
            if (!r[7]) r[6] = 1'b0;
            q.push_back(r[7:0]);
         end
         frame(q, 1'b1, 1'b1);
      end
      report_and_stop();
   end
   initial begin
      repeat (60000) @(posedge clk);
      fail_count++;
      $display("mismatch at %0t: watchdog expired", $time);
      report_and_stop();
   end
endmodule
